// file: rtl/mie_axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight.
// Decode and read data are supplied by the parent on the same clock.
`timescale 1ns/100ps
module mie_axil_slave
  import mie_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output mie_wcmd_s wcmd,
  output logic wr_fire,
  input wire logic [1:0] wr_resp,
  output logic [7:0] rd_addr,
  output logic rd_fire,
  input mie_rrsp_s rd_rsp
);

  logic aw_have_q;
  logic w_have_q;
  logic ar_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign wcmd = '{addr: aw_addr_q, data: w_data_q, strb: w_strb_q};

  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign rd_fire = ar_have_q & ~s_axi_rvalid;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_have_q) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_have_q) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_have_q <= 1'b0;
      s_axi_arready <= 1'b0;
      rd_addr <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_have_q <= 1'b1;
      s_axi_arready <= 1'b0;
      rd_addr <= s_axi_araddr;
    end else if (s_axi_rvalid && s_axi_rready) begin
      ar_have_q <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!ar_have_q) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_rsp.data;
      s_axi_rresp <= rd_rsp.resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : mie_axil_slave

// file: rtl/mie_gate.sv
// Per-event gating of latched status by individual and group enables.
// Status and enables come from logic on the same clock.
`timescale 1ns/100ps
module mie_gate
  import mie_pkg::*;
(
  input wire logic [31:0] status,
  input wire logic [31:0] enables,
  output logic [31:0] pending
);

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      if (NORMAL_EVENTS[i]) begin : g_norm
        // Normal event needs its own and the normal group enable
        assign pending[i] = status[i] & enables[i] & enables[BIT_NORMAL_GROUP];
      end else if (ABNORMAL_EVENTS[i]) begin : g_abn
        // Abnormal event needs its own and the abnormal group enable
        assign pending[i] = status[i] & enables[i] & enables[BIT_ABNORMAL_GROUP];
      end else begin : g_none
        assign pending[i] = 1'b0;
      end
    end
  endgenerate

endmodule : mie_gate

// file: rtl/mie_pkg.sv
// Package for the interrupt enable and mask block.
// Shared by the bus slave, the gating network and the top module.
package mie_pkg;

  // Register byte offsets
  localparam logic [7:0] ENABLE_MASK_OFF = 8'h38;
  localparam logic [7:0] PENDING_OFF = 8'h3c;

  // Reset value of the enable mask register
  localparam logic [31:0] ENABLE_MASK_RESET = 32'h0000_0000;

  // Field positions of the enable mask register and the pending view
  localparam int unsigned BIT_NORMAL_GROUP = 16;
  localparam int unsigned BIT_ABNORMAL_GROUP = 15;
  localparam int unsigned BIT_FATAL_BUS_ERROR = 13;
  localparam int unsigned BIT_TIMER_EXPIRY = 11;
  localparam int unsigned BIT_RX_WATCHDOG_TIMEOUT = 9;
  localparam int unsigned BIT_RX_STOPPED = 8;
  localparam int unsigned BIT_RX_DESC_UNAVAILABLE = 7;
  localparam int unsigned BIT_RX_COMPLETED = 6;
  localparam int unsigned BIT_TX_UNDERFLOW = 5;
  localparam int unsigned BIT_TX_JABBER_TIMEOUT = 3;
  localparam int unsigned BIT_TX_DESC_UNAVAILABLE = 2;
  localparam int unsigned BIT_TX_PROCESSOR_STOPPED = 1;
  localparam int unsigned BIT_TX_COMPLETED = 0;
  localparam int unsigned BIT_PENDING_IRQ = 31;

  // Event groups and writable bits
  localparam logic [31:0] NORMAL_EVENTS = 32'h0000_0045;
  localparam logic [31:0] ABNORMAL_EVENTS = 32'h0000_2baa;
  localparam logic [31:0] DEFINED_BITS = 32'h0001_abef;

  // AXI4-Lite response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write command from the bus slave
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } mie_wcmd_s;

  // Read answer to the bus slave
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } mie_rrsp_s;

endpackage : mie_pkg

// file: rtl/mie_top.sv
// Interrupt enable and mask register with group gating and request output.
// Expects latched status bits from the interrupt status register, same clock.
//
// What this block does
// - Bit 16 enables the normal event group
// - Bit 15 enables the abnormal event group
// - Fatal bus error needs bit 13 and 15
// - Timer expiry needs bit 11 and 15
// - Receive watchdog needs bit 9 and 15
// - Receive stopped needs bit 8 and 15
// - Receive descriptor unavailable needs 7 and 15
// - Receive completed needs bit 6 and 16
// - Transmit underflow needs bit 5 and 15
// - Transmit jabber timeout needs bit 3 and 15
// - Transmit descriptor unavailable needs 2 and 16
// - Transmit processor stopped needs 1 and 15
// - Transmit completed needs bit 0 and 16
// - Enable register sits at byte offset 38h
`timescale 1ns/100ps
module mie_top
  import mie_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] int_status,
  output logic irq
);

  mie_wcmd_s wcmd;
  mie_rrsp_s rd_rsp;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_addr;
  logic [1:0] wr_resp;
  logic [31:0] enable_mask_q;
  logic [31:0] enable_mask_d;
  logic [31:0] byte_mask;
  logic [31:0] pending;
  logic [31:0] pending_view;
  logic wr_enable_hit;
  logic wr_pending_hit;
  logic irq_q;

  assign irq = irq_q;

  // Bus front end
  mie_axil_slave mie_axil_slave_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wcmd(wcmd),
    .wr_fire(wr_fire),
    .wr_resp(wr_resp),
    .rd_addr(rd_addr),
    .rd_fire(rd_fire),
    .rd_rsp(rd_rsp)
  );

  // Event gating by individual and group enables
  mie_gate mie_gate_inst (
    .status(int_status),
    .enables(enable_mask_q),
    .pending(pending)
  );

  // Write address decode
  assign wr_enable_hit = (wcmd.addr[7:2] == ENABLE_MASK_OFF[7:2]);
  assign wr_pending_hit = (wcmd.addr[7:2] == PENDING_OFF[7:2]);

  // Read-only pending view accepts writes and ignores them
  assign wr_resp = (wr_enable_hit || wr_pending_hit) ? RESP_OKAY : RESP_SLVERR;

  // Byte lane mask from write strobes
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign byte_mask[b*8 +: 8] = {8{wcmd.strb[b]}};
    end
  endgenerate

  // Merge written lanes, keep reserved bits at zero
  always_comb begin
    enable_mask_d = (enable_mask_q & ~byte_mask) | (wcmd.data & byte_mask);
    enable_mask_d = enable_mask_d & DEFINED_BITS;
  end

  // Enable mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_mask_q <= ENABLE_MASK_RESET;
    end else if (wr_fire && wr_enable_hit) begin
      enable_mask_q <= enable_mask_d;
    end
  end

  // Interrupt request from any gated event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |pending;
    end
  end

  // Pending view: gated events, group summaries and request level
  always_comb begin
    pending_view = pending & DEFINED_BITS;
    pending_view[BIT_NORMAL_GROUP] = |(pending & NORMAL_EVENTS);
    pending_view[BIT_ABNORMAL_GROUP] = |(pending & ABNORMAL_EVENTS);
    pending_view[BIT_PENDING_IRQ] = irq_q;
  end

  // Read data mux
  always_comb begin
    rd_rsp.data = 32'h0000_0000;
    rd_rsp.resp = RESP_SLVERR;
    if (rd_addr[7:2] == ENABLE_MASK_OFF[7:2]) begin
      rd_rsp.data = enable_mask_q;
      rd_rsp.resp = RESP_OKAY;
    end else if (rd_addr[7:2] == PENDING_OFF[7:2]) begin
      rd_rsp.data = pending_view;
      rd_rsp.resp = RESP_OKAY;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_normal_group_off:
    assert property ((!enable_mask_q[BIT_NORMAL_GROUP]
                      && ((int_status & ABNORMAL_EVENTS) == 32'h0000_0000))
                     |=> !irq)
    else $error("normal events raised irq with group disabled");

  a_abnormal_group_off:
    assert property ((!enable_mask_q[BIT_ABNORMAL_GROUP]
                      && ((int_status & NORMAL_EVENTS) == 32'h0000_0000))
                     |=> !irq)
    else $error("abnormal events raised irq with group disabled");

  a_fatal_bus_irq:
    assert property ((int_status[BIT_FATAL_BUS_ERROR]
                      && enable_mask_q[BIT_FATAL_BUS_ERROR]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("fatal bus error did not raise irq");

  a_timer_irq:
    assert property ((int_status[BIT_TIMER_EXPIRY]
                      && enable_mask_q[BIT_TIMER_EXPIRY]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("timer expiry did not raise irq");

  a_rx_watchdog_irq:
    assert property ((int_status[BIT_RX_WATCHDOG_TIMEOUT]
                      && enable_mask_q[BIT_RX_WATCHDOG_TIMEOUT]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("receive watchdog did not raise irq");

  a_rx_stopped_irq:
    assert property ((int_status[BIT_RX_STOPPED]
                      && enable_mask_q[BIT_RX_STOPPED]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("receive stopped did not raise irq");

  a_rx_desc_irq:
    assert property ((int_status[BIT_RX_DESC_UNAVAILABLE]
                      && enable_mask_q[BIT_RX_DESC_UNAVAILABLE]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("receive descriptor unavailable did not raise irq");

  a_rx_done_irq:
    assert property ((int_status[BIT_RX_COMPLETED]
                      && enable_mask_q[BIT_RX_COMPLETED]
                      && enable_mask_q[BIT_NORMAL_GROUP]) |=> irq)
    else $error("receive completed did not raise irq");

  a_tx_underflow_irq:
    assert property ((int_status[BIT_TX_UNDERFLOW]
                      && enable_mask_q[BIT_TX_UNDERFLOW]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("transmit underflow did not raise irq");

  a_tx_jabber_irq:
    assert property ((int_status[BIT_TX_JABBER_TIMEOUT]
                      && enable_mask_q[BIT_TX_JABBER_TIMEOUT]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("transmit jabber timeout did not raise irq");

  a_tx_desc_irq:
    assert property ((int_status[BIT_TX_DESC_UNAVAILABLE]
                      && enable_mask_q[BIT_TX_DESC_UNAVAILABLE]
                      && enable_mask_q[BIT_NORMAL_GROUP]) |=> irq)
    else $error("transmit descriptor unavailable did not raise irq");

  a_tx_stopped_irq:
    assert property ((int_status[BIT_TX_PROCESSOR_STOPPED]
                      && enable_mask_q[BIT_TX_PROCESSOR_STOPPED]
                      && enable_mask_q[BIT_ABNORMAL_GROUP]) |=> irq)
    else $error("transmit processor stopped did not raise irq");

  a_tx_done_irq:
    assert property ((int_status[BIT_TX_COMPLETED]
                      && enable_mask_q[BIT_TX_COMPLETED]
                      && enable_mask_q[BIT_NORMAL_GROUP]) |=> irq)
    else $error("transmit completed did not raise irq");

  a_mask_write_lands:
    assert property ((wr_fire && wr_enable_hit && (wcmd.strb == 4'hf))
                     |=> (enable_mask_q == ($past(wcmd.data) & DEFINED_BITS))
                         ##0 s_axi_bvalid && (s_axi_bresp == RESP_OKAY))
    else $error("full write to enable mask did not land");

  a_unmapped_write:
    assert property ((wr_fire && !wr_enable_hit && !wr_pending_hit)
                     |=> $stable(enable_mask_q)
                         && s_axi_bvalid && (s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");

  a_irq_quiet:
    assert property ((pending == 32'h0000_0000)[*2] |=> !irq)
    else $error("irq high with nothing pending");

  a_irq_tracks:
    assert property ((|pending) |=> irq)
    else $error("irq missed a new pending event");

  a_reserved_zero:
    assert property ((enable_mask_q & ~DEFINED_BITS) == 32'h0000_0000)
    else $error("reserved enable bits set");

  a_reset_clear:
    assert property ($rose(aresetn) |-> (enable_mask_q == ENABLE_MASK_RESET) && !irq)
    else $error("enable mask not clear after reset");

  a_read_mask:
    assert property ((rd_fire && (rd_addr[7:2] == ENABLE_MASK_OFF[7:2]))
                     |=> s_axi_rvalid && (s_axi_rdata == $past(enable_mask_q))
                         && (s_axi_rresp == RESP_OKAY))
    else $error("enable mask read returned wrong data");

  a_groups_off_quiet:
    assert property ((!enable_mask_q[BIT_NORMAL_GROUP] && !enable_mask_q[BIT_ABNORMAL_GROUP])
                     |=> !irq)
    else $error("irq raised with both groups disabled");

  a_no_enabled_quiet:
    assert property (((int_status & enable_mask_q & (NORMAL_EVENTS | ABNORMAL_EVENTS))
                      == 32'h0000_0000) |=> !irq)
    else $error("irq raised with no enabled event");

  a_pending_write_ok:
    assert property ((wr_fire && wr_pending_hit)
                     |=> $stable(enable_mask_q)
                         && s_axi_bvalid && (s_axi_bresp == RESP_OKAY))
    else $error("write to pending view not ignored");

  a_unmapped_read:
    assert property ((rd_fire && (rd_addr[7:2] != ENABLE_MASK_OFF[7:2])
                      && (rd_addr[7:2] != PENDING_OFF[7:2]))
                     |=> s_axi_rvalid && (s_axi_rdata == 32'h0000_0000)
                         && (s_axi_rresp == RESP_SLVERR))
    else $error("unmapped read not refused");

  a_pending_read:
    assert property ((rd_fire && (rd_addr[7:2] == PENDING_OFF[7:2]))
                     |=> s_axi_rvalid && (s_axi_rresp == RESP_OKAY)
                         && (s_axi_rdata[BIT_PENDING_IRQ] == $past(irq))
                         && ((s_axi_rdata & ~(DEFINED_BITS | (32'h1 << BIT_PENDING_IRQ)))
                             == 32'h0000_0000))
    else $error("pending view read wrong");

  a_bresp_hold:
    assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  a_rdata_hold:
    assert property ((s_axi_rvalid && !s_axi_rready)
                     |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before taken");

  a_write_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response outstanding");

  a_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data outstanding");

  a_upper_lane_keep:
    assert property ((wr_fire && wr_enable_hit && !wcmd.strb[2])
                     |=> (enable_mask_q[23:16] == $past(enable_mask_q[23:16])))
    else $error("unstrobed lane two changed");

  a_middle_lane_keep:
    assert property ((wr_fire && wr_enable_hit && !wcmd.strb[1])
                     |=> (enable_mask_q[15:8] == $past(enable_mask_q[15:8])))
    else $error("unstrobed lane one changed");

  a_low_lane_keep:
    assert property ((wr_fire && wr_enable_hit && !wcmd.strb[0])
                     |=> (enable_mask_q[7:0] == $past(enable_mask_q[7:0])))
    else $error("unstrobed lane zero changed");

  a_bresp_code:
    assert property (s_axi_bvalid |-> (s_axi_bresp == RESP_OKAY) || (s_axi_bresp == RESP_SLVERR))
    else $error("write response code not defined");

  a_rresp_code:
    assert property (s_axi_rvalid |-> (s_axi_rresp == RESP_OKAY) || (s_axi_rresp == RESP_SLVERR))
    else $error("read response code not defined");

endmodule : mie_top

// file: sim/mie_top_test.sv
// Self-checking bench for the interrupt enable and mask block.
// Drives the AXI4-Lite port and the latched status bits directly.
`timescale 1ns/100ps
module mie_top_test;
  import mie_pkg::*;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] int_status = 32'h0;
  logic irq;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;

  mie_top mie_top_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .int_status(int_status),
    .irq(irq)
  );

  always #12.5 aclk = ~aclk;

  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // Cuts a hang short
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_r);
    bit aw_done;
    bit w_done;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, exp_r});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] exp_d,
                          input logic [1:0] exp_r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    chk(rdata, exp_d);
    chk({30'h0, rresp}, {30'h0, exp_r});
  endtask : axi_read

  // Applies a status pattern and checks the request once it has settled
  task automatic irq_chk(input logic [31:0] st, input logic exp);
    @(posedge aclk);
    int_status <= st;
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irq_chk

  task automatic test_reset_values();
    irq_chk(32'hffff_ffff, 1'b0);
    axi_read(ENABLE_MASK_OFF, 32'h0000_0000, RESP_OKAY);
  endtask : test_reset_values

  task automatic test_reserved_bits();
    axi_write(ENABLE_MASK_OFF, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_read(ENABLE_MASK_OFF, 32'h0001_abef, RESP_OKAY);
    irq_chk(~32'h0000_2bef, 1'b0);
    axi_write(ENABLE_MASK_OFF, 32'h0000_0000, 4'h3, RESP_OKAY);
    axi_read(ENABLE_MASK_OFF, 32'h0001_0000, RESP_OKAY);
    axi_write(ENABLE_MASK_OFF, 32'h0000_0000, 4'h4, RESP_OKAY);
    axi_read(ENABLE_MASK_OFF, 32'h0000_0000, RESP_OKAY);
  endtask : test_reserved_bits

  task automatic test_unmapped();
    axi_write(ENABLE_MASK_OFF, 32'h0000_8020, 4'hf, RESP_OKAY);
    axi_write(8'h40, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    axi_write(8'h34, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    axi_read(ENABLE_MASK_OFF, 32'h0000_8020, RESP_OKAY);
    axi_read(8'h40, 32'h0000_0000, RESP_SLVERR);
  endtask : test_unmapped

  // Each event against its own enable, its own group and the wrong group
  task automatic test_gating();
    logic [4:0] ev_bit [11];
    logic [31:0] b;
    logic [31:0] g;
    logic [31:0] o;
    ev_bit = '{5'd13, 5'd11, 5'd9, 5'd8, 5'd7, 5'd5, 5'd3, 5'd1, 5'd6, 5'd2, 5'd0};
    for (int i = 0; i < 11; i++) begin
      b = 32'h1 << ev_bit[i];
      g = (i < 8) ? 32'h0000_8000 : 32'h0001_0000;
      o = (i < 8) ? 32'h0001_0000 : 32'h0000_8000;
      axi_write(ENABLE_MASK_OFF, b | o, 4'hf, RESP_OKAY);
      irq_chk(b, 1'b0);
      axi_write(ENABLE_MASK_OFF, b | g, 4'hf, RESP_OKAY);
      irq_chk(b, 1'b1);
      irq_chk(32'h0000_2bef & ~b, 1'b0);
      axi_write(ENABLE_MASK_OFF, g | o | (32'h0001_abef & ~b), 4'hf, RESP_OKAY);
      irq_chk(b, 1'b0);
    end
    axi_write(ENABLE_MASK_OFF, 32'h0001_abef, 4'hf, RESP_OKAY);
    irq_chk(32'h0000_0001, 1'b1);
    irq_chk(32'h0000_0000, 1'b0);
  endtask : test_gating

  // Pending view: gated events, group summaries, request; writes ignored
  task automatic test_pending_view();
    axi_write(ENABLE_MASK_OFF, 32'h0001_abef, 4'hf, RESP_OKAY);
    irq_chk(32'h0000_2001, 1'b1);
    axi_read(PENDING_OFF, 32'h8001_a001, RESP_OKAY);
    axi_write(ENABLE_MASK_OFF, 32'h0000_abef, 4'hf, RESP_OKAY);
    irq_chk(32'h0000_2001, 1'b1);
    axi_read(PENDING_OFF, 32'h8000_a000, RESP_OKAY);
    axi_write(PENDING_OFF, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_read(ENABLE_MASK_OFF, 32'h0000_abef, RESP_OKAY);
    irq_chk(32'h0000_0000, 1'b0);
    axi_read(PENDING_OFF, 32'h0000_0000, RESP_OKAY);
  endtask : test_pending_view

  task automatic test_mid_reset();
    axi_write(ENABLE_MASK_OFF, 32'hffff_ffff, 4'hf, RESP_OKAY);
    irq_chk(32'h0000_2000, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ENABLE_MASK_OFF, 32'h0000_0000, RESP_OKAY);
    irq_chk(32'h0000_2bef, 1'b0);
  endtask : test_mid_reset

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset_values();
    test_reserved_bits();
    test_unmapped();
    test_gating();
    test_pending_view();
    test_mid_reset();
    finish_test();
  end

endmodule : mie_top_test
